// *** logic/asol_top.sv ***
// Local design decisions: the APB register port and the address map.
`default_nettype none

module asol_top (
    input wire logic I_CORE_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic I_RESET_BTN,
    input wire logic I_CFG_BTN,
    input wire logic I_ENT_BTN,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic [3:0] O_STATUS_OUT,
    output logic [2:0] O_RELAY,
    output logic O_ALARM_GREEN,
    output logic O_ALARM_AMBER,
    output logic O_ALARM_RED,
    output logic [1:0] O_UNIT_LED,
    output logic [15:0] O_DISP_CHARS,
    output logic [11:0] O_LEVEL_OUTPUT_PIN,
    output logic O_LEVEL_CURRENT_MODE,
    output logic [1:0] O_COMM_MODE
);

    typedef struct packed {
        logic [1:0] alarm_en;
        logic latch;
        logic unit;
        logic amode;
        asol_pkg::asol_comm_t comm;
        logic ready;
        logic [4:0] delay;
        logic [15:0] limit1;
        logic [15:0] limit2;
        logic [15:0] range;
        logic [15:0] conc;
        logic [15:0] lamp_lvl;
        logic [15:0] lamp_thr;
        logic [2:0] diag;
        logic sample;
        asol_pkg::asol_disp_t disp;
        logic [1:0] depth;
        logic [2:0] btn_s1;
        logic [2:0] btn_s2;
        logic [2:0] btn_prev;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [3:0] status;
        logic [2:0] relay;
        logic [2:0] led;
        logic [1:0] unit_led;
        logic [15:0] chars;
        logic [11:0] lvl_code;
        logic amode_o;
        logic [1:0] comm_o;
    } asol_top_st_t;

    localparam asol_top_st_t TOP_RST = '{
        default: '0,
        alarm_en: {asol_pkg::RST_ALARM_EN, asol_pkg::RST_ALARM_EN},
        latch: asol_pkg::RST_LATCH,
        delay: asol_pkg::RST_DELAY,
        limit1: asol_pkg::RST_LIMIT1,
        limit2: asol_pkg::RST_LIMIT2,
        range: asol_pkg::RST_RANGE,
        comm: asol_pkg::COMM_P2P,
        disp: asol_pkg::DISP_START,
        chars: {4{asol_pkg::CHAR_START}},
        led: asol_pkg::RST_LED
    };

    asol_top_st_t st_ff;
    asol_top_st_t nxt_st;

    logic [2:0] btn_edge;
    logic [1:0] alarm_act;

    // Button edges look only at the second synchroniser stage.
    assign btn_edge = st_ff.btn_s2 & ~st_ff.btn_prev;

    // Alarm evaluation runs apart from the display state machine, so menus never stall it.
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : gen_alarm
            asol_alarm_if alm ();
            assign alm.sample = st_ff.sample;
            assign alm.conc = st_ff.conc;
            assign alm.limit = (g == 0) ? st_ff.limit1 : st_ff.limit2;
            assign alm.enable = st_ff.alarm_en[g];
            assign alm.latch = st_ff.latch;
            assign alm.delay = st_ff.delay;
            assign alm.reset_press = btn_edge[0];
            assign alarm_act[g] = alm.active;
            asol_alarm_chan u_chan (
                .i_clk(I_CORE_CLK),
                .i_rst(I_SYS_RST),
                .alm(alm.chan)
            );
        end
    endgenerate

    always_comb
    begin
        logic access;
        logic commit;
        logic mapped;
        logic [31:0] rdata;
        logic [4:0] wdelay;
        logic [1:0] wcomm;
        logic [31:0] num;
        logic [31:0] quot;
        logic [11:0] span;
        logic [11:0] base;
        logic lamp_check;
        access = I_PSEL && I_PENABLE;
        commit = access && st_ff.pready;
        mapped = 1'b0;
        rdata = 32'h00000000;
        wdelay = I_PWDATA[asol_pkg::CTRL_DELAY_LSB +: 5];
        wcomm = I_PWDATA[asol_pkg::CTRL_COMM_LSB +: 2];
        num = 32'h00000000;
        quot = 32'h00000000;
        span = asol_pkg::LVL_VOLT_SPAN;
        base = 12'h000;
        lamp_check = st_ff.lamp_lvl < st_ff.lamp_thr;
        nxt_st = st_ff;

        nxt_st.btn_s1 = {I_ENT_BTN, I_CFG_BTN, I_RESET_BTN};
        nxt_st.btn_s2 = st_ff.btn_s1;
        nxt_st.btn_prev = st_ff.btn_s2;
        nxt_st.sample = 1'b0;

        case (I_PADDR)
            asol_pkg::ADDR_CTRL:
            begin
                mapped = 1'b1;
                rdata[asol_pkg::CTRL_EN1_BIT] = st_ff.alarm_en[0];
                rdata[asol_pkg::CTRL_EN2_BIT] = st_ff.alarm_en[1];
                rdata[asol_pkg::CTRL_LATCH_BIT] = st_ff.latch;
                rdata[asol_pkg::CTRL_UNIT_BIT] = st_ff.unit;
                rdata[asol_pkg::CTRL_AMODE_BIT] = st_ff.amode;
                rdata[asol_pkg::CTRL_COMM_LSB +: 2] = st_ff.comm;
                rdata[asol_pkg::CTRL_READY_BIT] = st_ff.ready;
                rdata[asol_pkg::CTRL_DELAY_LSB +: 5] = st_ff.delay;
            end
            asol_pkg::ADDR_LIMIT1:
            begin
                mapped = 1'b1;
                rdata[15:0] = st_ff.limit1;
            end
            asol_pkg::ADDR_LIMIT2:
            begin
                mapped = 1'b1;
                rdata[15:0] = st_ff.limit2;
            end
            asol_pkg::ADDR_RANGE:
            begin
                mapped = 1'b1;
                rdata[15:0] = st_ff.range;
            end
            asol_pkg::ADDR_CONC:
            begin
                mapped = 1'b1;
                rdata[15:0] = st_ff.conc;
            end
            asol_pkg::ADDR_DIAG:
            begin
                mapped = 1'b1;
                rdata[2:0] = st_ff.diag;
            end
            asol_pkg::ADDR_LAMP:
            begin
                mapped = 1'b1;
                rdata = {st_ff.lamp_thr, st_ff.lamp_lvl};
            end
            asol_pkg::ADDR_STAT:
            begin
                mapped = 1'b1;
                rdata[asol_pkg::STAT_ALARM_LSB +: 2] = alarm_act;
                rdata[asol_pkg::STAT_DISP_LSB +: 2] = st_ff.disp;
                rdata[asol_pkg::STAT_DEPTH_LSB +: 2] = st_ff.depth;
                rdata[asol_pkg::STAT_LAMP_BIT] = lamp_check;
                rdata[asol_pkg::STAT_LEVEL_LSB +: 12] = st_ff.lvl_code;
            end
            default:
            begin
                mapped = 1'b0;
            end
        endcase

        // One wait state: ready rises in the second access cycle, when the word is latched.
        nxt_st.pready = access && !st_ff.pready;
        if (access && !st_ff.pready)
        begin
            nxt_st.prdata = I_PWRITE ? 32'h00000000 : rdata;
            nxt_st.pslverr = !mapped;
        end
        else
        begin
            nxt_st.pslverr = 1'b0;
        end

        if (commit && I_PWRITE)
        begin
            case (I_PADDR)
                asol_pkg::ADDR_CTRL:
                begin
                    nxt_st.alarm_en[0] = I_PWDATA[asol_pkg::CTRL_EN1_BIT];
                    nxt_st.alarm_en[1] = I_PWDATA[asol_pkg::CTRL_EN2_BIT];
                    nxt_st.latch = I_PWDATA[asol_pkg::CTRL_LATCH_BIT];
                    nxt_st.unit = I_PWDATA[asol_pkg::CTRL_UNIT_BIT];
                    nxt_st.amode = I_PWDATA[asol_pkg::CTRL_AMODE_BIT];
                    nxt_st.ready = I_PWDATA[asol_pkg::CTRL_READY_BIT];
                    if (wcomm != 2'h3)
                    begin
                        nxt_st.comm = asol_pkg::asol_comm_t'(wcomm);
                    end
                    // Out-of-range counts are dropped, and the delay keeps its old value.
                    if (wdelay >= asol_pkg::DELAY_MIN && wdelay <= asol_pkg::DELAY_MAX)
                    begin
                        nxt_st.delay = wdelay;
                    end
                end
                asol_pkg::ADDR_LIMIT1:
                begin
                    nxt_st.limit1 = I_PWDATA[15:0];
                end
                asol_pkg::ADDR_LIMIT2:
                begin
                    nxt_st.limit2 = I_PWDATA[15:0];
                end
                asol_pkg::ADDR_RANGE:
                begin
                    nxt_st.range = I_PWDATA[15:0];
                end
                asol_pkg::ADDR_CONC:
                begin
                    nxt_st.conc = I_PWDATA[15:0];
                    nxt_st.sample = 1'b1;
                end
                asol_pkg::ADDR_DIAG:
                begin
                    nxt_st.diag = I_PWDATA[2:0];
                end
                asol_pkg::ADDR_LAMP:
                begin
                    nxt_st.lamp_lvl = I_PWDATA[15:0];
                    nxt_st.lamp_thr = I_PWDATA[31:16];
                end
                default:
                begin
                    nxt_st.conc = st_ff.conc;
                end
            endcase
        end

        case (st_ff.disp)
            asol_pkg::DISP_START:
            begin
                if (st_ff.ready)
                begin
                    nxt_st.disp = asol_pkg::DISP_CONC;
                end
            end
            asol_pkg::DISP_CONC:
            begin
                if (btn_edge[1])
                begin
                    nxt_st.disp = asol_pkg::DISP_MENU;
                    nxt_st.depth = 2'h1;
                end
            end
            asol_pkg::DISP_MENU:
            begin
                if (btn_edge[1])
                begin
                    if (st_ff.depth == 2'h1)
                    begin
                        nxt_st.disp = asol_pkg::DISP_CONC;
                        nxt_st.depth = 2'h0;
                    end
                    else
                    begin
                        nxt_st.depth = st_ff.depth - 2'h1;
                    end
                end
                else if (btn_edge[2] && st_ff.depth < asol_pkg::MENU_MAX_DEPTH)
                begin
                    nxt_st.depth = st_ff.depth + 2'h1;
                end
            end
            default:
            begin
                nxt_st.disp = asol_pkg::DISP_START;
            end
        endcase
        if (!st_ff.ready)
        begin
            nxt_st.disp = asol_pkg::DISP_START;
            nxt_st.depth = 2'h0;
        end

        // A zero range would divide by zero, so it pins the output to full scale.
        if (st_ff.amode)
        begin
            span = asol_pkg::LVL_CURR_SPAN;
            base = asol_pkg::LVL_CURR_BASE;
        end
        num = {16'h0000, st_ff.conc} * {20'h00000, span};
        quot = (st_ff.range == 16'h0000) ? {20'h00000, span} : num / {16'h0000, st_ff.range};
        if (quot > {20'h00000, span})
        begin
            quot = {20'h00000, span};
        end
        nxt_st.lvl_code = base + quot[11:0];
        nxt_st.amode_o = st_ff.amode;
        nxt_st.comm_o = st_ff.comm;

        nxt_st.status = {st_ff.diag[asol_pkg::DIAG_PNEU_BIT], lamp_check,
                         st_ff.diag[asol_pkg::DIAG_INVALID_BIT], st_ff.diag[asol_pkg::DIAG_OK_BIT]};
        nxt_st.relay = {alarm_act[1], alarm_act[0], st_ff.diag[asol_pkg::DIAG_OK_BIT]};
        if (alarm_act[1])
        begin
            nxt_st.led = 3'h4;
        end
        else if (alarm_act[0])
        begin
            nxt_st.led = 3'h2;
        end
        else
        begin
            nxt_st.led = 3'h1;
        end

        if (st_ff.disp == asol_pkg::DISP_CONC)
        begin
            nxt_st.unit_led = st_ff.unit ? 2'h2 : 2'h1;
            nxt_st.chars = st_ff.conc;
        end
        else
        begin
            nxt_st.unit_led = 2'h0;
            nxt_st.chars = (st_ff.disp == asol_pkg::DISP_START) ? {4{asol_pkg::CHAR_START}}
                                                                 : {4{asol_pkg::CHAR_BLANK}};
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST)
    begin
        if (I_SYS_RST)
        begin
            st_ff <= TOP_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign O_PRDATA = st_ff.prdata;
    assign O_PREADY = st_ff.pready;
    assign O_PSLVERR = st_ff.pslverr;
    assign O_STATUS_OUT = st_ff.status;
    assign O_RELAY = st_ff.relay;
    assign O_ALARM_GREEN = st_ff.led[0];
    assign O_ALARM_AMBER = st_ff.led[1];
    assign O_ALARM_RED = st_ff.led[2];
    assign O_UNIT_LED = st_ff.unit_led;
    assign O_DISP_CHARS = st_ff.chars;
    assign O_LEVEL_OUTPUT_PIN = st_ff.lvl_code;
    assign O_LEVEL_CURRENT_MODE = st_ff.amode_o;
    assign O_COMM_MODE = st_ff.comm_o;

endmodule : asol_top

`default_nettype wire

// *** logic/asol_pkg.sv ***
`default_nettype none

package asol_pkg;

    // Register byte addresses on the APB bus.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LIMIT1 = 8'h04;
    localparam logic [7:0] ADDR_LIMIT2 = 8'h08;
    localparam logic [7:0] ADDR_RANGE = 8'h0c;
    localparam logic [7:0] ADDR_CONC = 8'h10;
    localparam logic [7:0] ADDR_DIAG = 8'h14;
    localparam logic [7:0] ADDR_LAMP = 8'h18;
    localparam logic [7:0] ADDR_STAT = 8'h1c;

    // Control register field positions.
    localparam int CTRL_EN1_BIT = 0;
    localparam int CTRL_EN2_BIT = 1;
    localparam int CTRL_LATCH_BIT = 2;
    localparam int CTRL_UNIT_BIT = 3;
    localparam int CTRL_AMODE_BIT = 4;
    localparam int CTRL_COMM_LSB = 5;
    localparam int CTRL_READY_BIT = 7;
    localparam int CTRL_DELAY_LSB = 8;

    // Diagnostic register field positions.
    localparam int DIAG_OK_BIT = 0;
    localparam int DIAG_INVALID_BIT = 1;
    localparam int DIAG_PNEU_BIT = 2;

    // Status register field positions.
    localparam int STAT_ALARM_LSB = 0;
    localparam int STAT_DISP_LSB = 2;
    localparam int STAT_DEPTH_LSB = 4;
    localparam int STAT_LAMP_BIT = 6;
    localparam int STAT_LEVEL_LSB = 16;

    // Values after reset.
    localparam logic RST_ALARM_EN = 1'h1;
    localparam logic RST_LATCH = 1'h1;
    localparam logic [4:0] RST_DELAY = 5'h05;
    localparam logic [15:0] RST_LIMIT1 = 16'h0064;
    localparam logic [15:0] RST_LIMIT2 = 16'h0066;
    localparam logic [15:0] RST_RANGE = 16'h07d0;
    localparam logic [2:0] RST_LED = 3'h1;

    // Limits of the consecutive-reading count.
    localparam logic [4:0] DELAY_MIN = 5'h01;
    localparam logic [4:0] DELAY_MAX = 5'h14;

    // Analog output codes, 12 bits; current loop starts at one fifth of full scale.
    localparam logic [11:0] LVL_VOLT_SPAN = 12'hfff;
    localparam logic [11:0] LVL_CURR_SPAN = 12'hccc;
    localparam logic [11:0] LVL_CURR_BASE = 12'h333;

    // Display characters and menu depth.
    localparam logic [3:0] CHAR_START = 4'he;
    localparam logic [3:0] CHAR_BLANK = 4'hf;
    localparam logic [1:0] MENU_MAX_DEPTH = 2'h3;

    typedef enum logic [1:0] {
        DISP_START,
        DISP_CONC,
        DISP_MENU
    } asol_disp_t;

    typedef enum logic [1:0] {
        COMM_P2P,
        COMM_MULTIDROP,
        COMM_NET
    } asol_comm_t;

endpackage : asol_pkg

`default_nettype wire

// *** logic/asol_alarm_if.sv ***
`default_nettype none

interface asol_alarm_if;
    logic sample;
    logic [15:0] conc;
    logic [15:0] limit;
    logic enable;
    logic latch;
    logic [4:0] delay;
    logic reset_press;
    logic active;

    modport ctrl (
        output sample,
        output conc,
        output limit,
        output enable,
        output latch,
        output delay,
        output reset_press,
        input active
    );

    modport chan (
        input sample,
        input conc,
        input limit,
        input enable,
        input latch,
        input delay,
        input reset_press,
        output active
    );
endinterface : asol_alarm_if

`default_nettype wire

// *** logic/asol_alarm_chan.sv ***
`default_nettype none

module asol_alarm_chan (
    input wire logic i_clk,
    input wire logic i_rst,
    asol_alarm_if.chan alm
);

    typedef struct packed {
        logic [4:0] cnt;
        logic active;
        logic below;
    } asol_chan_st_t;

    localparam asol_chan_st_t CHAN_RST = '{cnt: 5'h00, active: 1'b0, below: 1'b1};

    asol_chan_st_t st_ff;
    asol_chan_st_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        if (!alm.enable)
        begin
            nxt_st = CHAN_RST;
        end
        else
        begin
            if (alm.sample)
            begin
                if (alm.conc > alm.limit)
                begin
                    // The count saturates so a long excursion cannot wrap back under the delay.
                    if (st_ff.cnt < alm.delay)
                    begin
                        nxt_st.cnt = st_ff.cnt + 5'h01;
                    end
                    if ({1'b0, st_ff.cnt} + 6'h01 >= {1'b0, alm.delay})
                    begin
                        nxt_st.active = 1'b1;
                    end
                    nxt_st.below = 1'b0;
                end
                else
                begin
                    nxt_st.cnt = 5'h00;
                    nxt_st.below = 1'b1;
                    if (!alm.latch)
                    begin
                        nxt_st.active = 1'b0;
                    end
                end
            end
            if (alm.latch && alm.reset_press && nxt_st.below)
            begin
                nxt_st.active = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            st_ff <= CHAN_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign alm.active = st_ff.active;

endmodule : asol_alarm_chan

`default_nettype wire

// *** verif/asol_monitor.sv ***
`default_nettype none

module asol_monitor (
    input wire logic I_CORE_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_CFG_BTN,
    input wire logic O_PREADY,
    input wire logic [3:0] O_STATUS_OUT,
    input wire logic [2:0] O_RELAY,
    input wire logic O_ALARM_GREEN,
    input wire logic O_ALARM_AMBER,
    input wire logic O_ALARM_RED,
    input wire logic [1:0] O_UNIT_LED,
    input wire logic [15:0] O_DISP_CHARS,
    input wire logic [1:0] O_COMM_MODE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_SYS_RST);

    sequence s_access;
        I_PSEL && I_PENABLE && !O_PREADY;
    endsequence
    sequence s_cfg_in_conc;
        $rose(I_CFG_BTN) && O_UNIT_LED != 2'h0;
    endsequence

    property p_ready;
        s_access |=> O_PREADY;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not one cycle after access");
    property p_relay1;
        O_RELAY[0] == O_STATUS_OUT[0];
    endproperty
    a_relay1: assert property (p_relay1) else $error("relay 1 differs from status 1");
    property p_green;
        O_ALARM_GREEN == !(O_RELAY[1] || O_RELAY[2]);
    endproperty
    a_green: assert property (p_green) else $error("green wrong");
    property p_amber;
        O_ALARM_AMBER == (O_RELAY[1] && !O_RELAY[2]);
    endproperty
    a_amber: assert property (p_amber) else $error("amber wrong");
    property p_red;
        O_ALARM_RED == O_RELAY[2];
    endproperty
    a_red: assert property (p_red) else $error("red wrong");
    property p_unit;
        $countones(O_UNIT_LED) <= 1;
    endproperty
    a_unit: assert property (p_unit) else $error("two unit lamps lit");
    property p_blank;
        O_UNIT_LED == 2'h0 |-> (O_DISP_CHARS == 16'heeee || O_DISP_CHARS == 16'hffff);
    endproperty
    a_blank: assert property (p_blank) else $error("value shown without unit");
    property p_cfg;
        s_cfg_in_conc |-> ##[1:8] O_UNIT_LED == 2'h0;
    endproperty
    a_cfg: assert property (p_cfg) else $error("menu not entered");
    property p_comm;
        O_COMM_MODE != 2'h3;
    endproperty
    a_comm: assert property (p_comm) else $error("illegal port mode");
endmodule : asol_monitor

bind asol_top asol_monitor u_mon (
    .I_CORE_CLK(I_CORE_CLK), .I_SYS_RST(I_SYS_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_CFG_BTN(I_CFG_BTN), .O_PREADY(O_PREADY), .O_STATUS_OUT(O_STATUS_OUT), .O_RELAY(O_RELAY),
    .O_ALARM_GREEN(O_ALARM_GREEN), .O_ALARM_AMBER(O_ALARM_AMBER), .O_ALARM_RED(O_ALARM_RED),
    .O_UNIT_LED(O_UNIT_LED), .O_DISP_CHARS(O_DISP_CHARS), .O_COMM_MODE(O_COMM_MODE)
);

`default_nettype wire

// *** verif/asol_loads.sv ***
`default_nettype none

module asol_loads (
    input wire logic [2:0] i_relay,
    input wire logic [3:0] i_status,
    output logic [2:0] o_nc_closed,
    output logic [3:0] o_contact_closed
);
    timeunit 1ns;
    timeprecision 1ps;
    // A form-C relay opens its normally-closed leg only while energized.
    assign o_nc_closed = ~i_relay;
    // Dry contacts have no polarity, so a closed contact is the status level.
    assign o_contact_closed = i_status;
endmodule : asol_loads

`default_nettype wire

// *** verif/testbench.sv ***
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [2:0] btn = 3'h0;
    logic [31:0] q, prdata;
    logic e, pready, pslverr, grn, amb, red, cm;
    logic [3:0] st, contact;
    logic [2:0] rly, nc;
    logic [1:0] unit, comm;
    logic [15:0] chars;
    logic [11:0] lvl;
    int fail_count = 0;
    int n_checks = 0;

    always #10 clk = ~clk;

    asol_top DUT (
        .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PADDR(pa), .I_PWDATA(pwd), .I_RESET_BTN(btn[0]), .I_CFG_BTN(btn[1]), .I_ENT_BTN(btn[2]),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .O_STATUS_OUT(st), .O_RELAY(rly),
        .O_ALARM_GREEN(grn), .O_ALARM_AMBER(amb), .O_ALARM_RED(red), .O_UNIT_LED(unit),
        .O_DISP_CHARS(chars), .O_LEVEL_OUTPUT_PIN(lvl), .O_LEVEL_CURRENT_MODE(cm), .O_COMM_MODE(comm)
    );
    asol_loads u_loads (.i_relay(rly), .i_status(st), .o_nc_closed(nc), .o_contact_closed(contact));

    task automatic test_done();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
        n_checks++;
        if (sn !== ex)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, ex, sn);
        end
    endtask : chk

    // The request is held until the edge that samples ready, so a write lands exactly once.
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= ad;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (k >= 20)
        begin
            fail_count++;
            test_done();
        end
    endtask : apb

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        apb(1'b1, ad, d);
        repeat (5) @(posedge clk);
    endtask : wr

    task automatic press(input int b);
        @(posedge clk);
        btn[b] <= 1'b1;
        repeat (3) @(posedge clk);
        btn[b] <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : press

    task automatic ca(input logic [4:0] ex);
        chk("alarm", 32'(ex), 32'({red, amb, grn, rly[2:1]}));
    endtask : ca

    task automatic t_reset();
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl", 32'h0507, q);
        chk("chars", 32'heeee, 32'(chars));
        ca(5'h04);
        apb(1'b0, 8'h20, 32'h0);
        chk("err", 32'h1, 32'(e));
        chk("rdata", 32'h0, q);
    endtask : t_reset

    task automatic t_status();
        wr(8'h14, 32'h1);
        chk("status", 32'h1, 32'(st));
        chk("nc", 32'h6, 32'(nc));
        wr(8'h14, 32'h6);
        chk("status", 32'ha, 32'(contact));
        wr(8'h18, 32'h000a0005);
        chk("status", 32'he, 32'(st));
        wr(8'h18, 32'h0005000a);
        wr(8'h14, 32'h1);
    endtask : t_status

    task automatic t_latch();
        wr(8'h00, 32'h0287);
        wr(8'h10, 32'h65);
        ca(5'h04);
        wr(8'h10, 32'h65);
        ca(5'h09);
        wr(8'h10, 32'h70);
        wr(8'h10, 32'h70);
        ca(5'h13);
        press(0);
        ca(5'h13);
        wr(8'h10, 32'h10);
        ca(5'h13);
        press(0);
        ca(5'h04);
    endtask : t_latch

    task automatic t_nonlatch();
        wr(8'h10, 32'h70);
        wr(8'h10, 32'h70);
        wr(8'h10, 32'h10);
        wr(8'h00, 32'h0183);
        press(0);
        ca(5'h13);
        wr(8'h10, 32'h10);
        ca(5'h04);
        wr(8'h10, 32'h70);
        ca(5'h13);
        wr(8'h10, 32'h65);
        ca(5'h09);
        wr(8'h00, 32'h0182);
        wr(8'h10, 32'h65);
        ca(5'h04);
        wr(8'h10, 32'h70);
        ca(5'h12);
        wr(8'h10, 32'h0);
        ca(5'h04);
    endtask : t_nonlatch

    task automatic t_disp();
        wr(8'h00, 32'h0188);
        wr(8'h10, 32'h1234);
        chk("unit", 32'h2, 32'(unit));
        chk("chars", 32'h1234, 32'(chars));
        press(1);
        chk("chars", 32'hffff, 32'(chars));
        wr(8'h00, 32'h0189);
        wr(8'h10, 32'h1234);
        ca(5'h09);
        press(2);
        press(1);
        chk("unit", 32'h0, 32'(unit));
        press(1);
        chk("unit", 32'h2, 32'(unit));
    endtask : t_disp

    task automatic t_level();
        wr(8'h00, 32'h0180);
        wr(8'h10, 32'h3e8);
        chk("level", 32'h7ff, 32'(lvl));
        chk("unit", 32'h1, 32'(unit));
        wr(8'h00, 32'h0190);
        chk("level", 32'h999, 32'(lvl));
        chk("loop", 32'h1, 32'(cm));
        wr(8'h10, 32'h0);
        chk("level", 32'h333, 32'(lvl));
        wr(8'h10, 32'h7d0);
        chk("level", 32'hfff, 32'(lvl));
    endtask : t_level

    task automatic t_comm();
        for (int c = 0; c < 3; c++)
        begin
            wr(8'h00, 32'h0180 | (32'(c) << 5));
            chk("comm", 32'(c), 32'(comm));
        end
        wr(8'h00, 32'h01e0);
        chk("comm", 32'h2, 32'(comm));
        wr(8'h00, 32'h15e0);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl", 32'h01c0, q);
    endtask : t_comm

    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_status();
        t_latch();
        t_nonlatch();
        t_disp();
        t_level();
        t_comm();
        test_done();
    end
endmodule : testbench

`default_nettype wire
